// [core/mie_core.sv]
`timescale 1ns/1ps
`include "mie_defs.svh"
module mie_core #(
   parameter int ROM_W = 14
) (
   input wire logic i_mclk,
   input wire logic i_rst_b,
   input wire logic i_start,
   input wire mie_pkg::mie_op_e i_op,
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_mem,
   input wire logic [7:0] i_imm,
   input wire logic [2:0] i_bit,
   input wire logic [ROM_W-1:0] i_rom,
   input wire logic i_wake,
   output logic o_busy,
   output logic o_done,
   output logic o_skip,
   output logic o_mem_we,
   output logic [7:0] o_mem_wdata,
   output logic [7:0] o_acc,
   output logic o_zero,
   output logic o_carry,
   output logic [ROM_W-9:0] o_table_high_latch,
   output logic o_timeout_flag,
   output logic o_powerdown_flag,
   output logic o_wdt_clear,
   output logic o_halted,
   output logic o_rom_req,
   output logic o_rom_last_page,
   output logic o_pc_load
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   // every register of the core lives in this one struct
   typedef struct packed {
      mie_pkg::mie_st_e st;
      logic [4:0] cnt;
      logic busy;
      logic done;
      logic skip;
      logic we;
      logic [7:0] wd;
      logic [7:0] acc;
      logic z;
      logic c;
      logic [ROM_W-9:0] tbh;
      logic to;
      logic powerdown_flag;
      logic wdt;
      logic pre1;
      logic pre2;
      logic rreq;
      logic rlast;
      logic program_counter_low;
      // halted copy kept as a flop so the pin has no decode behind it
      logic hlt;
      // wake pin synchroniser, oldest stage in the top bit
      logic [2:0] wk;
   } mie_state_s;

   mie_state_s s_q, s_d;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic is_zero(input logic [7:0] v);
      is_zero = (v == `MIE_ZERO_BYTE);
   endfunction

   // ----------------------------------------------------------------
   // execute
   // ----------------------------------------------------------------
   always_comb begin
      logic [7:0] r;
      logic cyc2;
      logic skp;
      logic wr;
      r = i_mem;
      cyc2 = 1'b0;
      skp = 1'b0;
      wr = 1'b0;
      s_d = s_q;
      s_d.done = 1'b0;
      s_d.we = 1'b0;
      s_d.wdt = 1'b0;
      s_d.program_counter_low = 1'b0;
      s_d.rreq = 1'b0;
      // wake comes from a pin: three stages, acted on once the two
      // oldest agree, so a glitch or a metastable sample cannot leave halt
      s_d.wk = {s_q.wk[1:0], i_wake};
      case (s_q.st)
         mie_pkg::ST_IDLE: begin
            if (i_start) begin
               s_d.busy = 1'b1;
               s_d.skip = 1'b0;
               case (i_op)
                  mie_pkg::OP_AND_X: begin
                     s_d.acc = s_q.acc & i_imm; // [RL1]
                     s_d.z = is_zero(s_q.acc & i_imm); // [RL1]
                  end
                  mie_pkg::OP_OR_X: begin
                     s_d.acc = s_q.acc | i_imm; // [RL1]
                     s_d.z = is_zero(s_q.acc | i_imm);
                  end
                  mie_pkg::OP_XOR_X: begin
                     s_d.acc = s_q.acc ^ i_imm; // [RL1]
                     s_d.z = is_zero(s_q.acc ^ i_imm);
                  end
                  mie_pkg::OP_CPL: begin
                     r = ~i_mem; // [RL2]
                     wr = 1'b1;
                     s_d.z = is_zero(r);
                  end
                  mie_pkg::OP_COMPLEMENT_TO_ACCUMULATOR: begin
                     s_d.acc = ~i_mem; // [RL2]
                     s_d.z = is_zero(~i_mem);
                  end
                  mie_pkg::OP_INC: begin
                     r = i_mem + 8'h01; // [RL3]
                     wr = 1'b1;
                     s_d.z = is_zero(r);
                  end
                  mie_pkg::OP_INCREMENT_TO_ACCUMULATOR: begin
                     r = i_mem + 8'h01; // [RL3]
                     s_d.acc = r;
                     s_d.z = is_zero(r);
                  end
                  mie_pkg::OP_DEC: begin
                     r = i_mem - 8'h01; // [RL3]
                     wr = 1'b1;
                     s_d.z = is_zero(r);
                  end
                  mie_pkg::OP_DECREMENT_TO_ACCUMULATOR: begin
                     r = i_mem - 8'h01; // [RL3]
                     s_d.acc = r;
                     s_d.z = is_zero(r);
                  end
                  mie_pkg::OP_RR: begin
                     r = {i_mem[0], i_mem[7:1]}; // [RL4]
                     wr = 1'b1;
                  end
                  mie_pkg::OP_RRA: begin
                     s_d.acc = {i_mem[0], i_mem[7:1]}; // [RL4]
                  end
                  mie_pkg::OP_RL: begin
                     r = {i_mem[6:0], i_mem[7]}; // [RL4]
                     wr = 1'b1;
                  end
                  mie_pkg::OP_RLA: begin
                     s_d.acc = {i_mem[6:0], i_mem[7]}; // [RL4]
                  end
                  mie_pkg::OP_RRC: begin
                     r = {s_q.c, i_mem[7:1]}; // [RL5]
                     s_d.c = i_mem[0];
                     wr = 1'b1;
                  end
                  mie_pkg::OP_RRCA: begin
                     s_d.acc = {s_q.c, i_mem[7:1]}; // [RL5]
                     s_d.c = i_mem[0];
                  end
                  mie_pkg::OP_RLC: begin
                     r = {i_mem[6:0], s_q.c}; // [RL5]
                     s_d.c = i_mem[7];
                     wr = 1'b1;
                  end
                  mie_pkg::OP_RLCA: begin
                     s_d.acc = {i_mem[6:0], s_q.c}; // [RL5]
                     s_d.c = i_mem[7];
                  end
                  mie_pkg::OP_MOV_AM: s_d.acc = i_mem; // [RL6]
                  mie_pkg::OP_MOV_AX: s_d.acc = i_imm; // [RL6]
                  mie_pkg::OP_MOV_MA: begin
                     r = s_q.acc; // [RL6]
                     wr = 1'b1;
                  end
                  mie_pkg::OP_CLR_BIT: begin
                     r = i_mem & ~(8'h01 << i_bit); // [RL7]
                     wr = 1'b1;
                  end
                  mie_pkg::OP_SET_BIT: begin
                     r = i_mem | (8'h01 << i_bit); // [RL7]
                     wr = 1'b1;
                  end
                  mie_pkg::OP_JMP, mie_pkg::OP_CALL, mie_pkg::OP_RET,
                  mie_pkg::OP_INTERRUPT_RETURN: begin
                     cyc2 = 1'b1; // [RL8]
                  end
                  mie_pkg::OP_RET_X: begin
                     s_d.acc = i_imm; // [RL8]
                     cyc2 = 1'b1;
                  end
                  mie_pkg::OP_SZ: skp = is_zero(i_mem); // [RL9]
                  mie_pkg::OP_SZ_BIT: skp = ~i_mem[i_bit]; // [RL9]
                  mie_pkg::OP_SNZ_BIT: skp = i_mem[i_bit]; // [RL9]
                  mie_pkg::OP_SZA: begin
                     s_d.acc = i_mem; // [RL10]
                     skp = is_zero(i_mem);
                  end
                  mie_pkg::OP_SIZ, mie_pkg::OP_SDZ: begin
                     r = (i_op == mie_pkg::OP_SIZ) ? i_mem + 8'h01
                                                   : i_mem - 8'h01;
                     wr = 1'b1; // [RL11]
                     skp = is_zero(r);
                  end
                  mie_pkg::OP_INCREMENT_SKIP_ZERO_ACC, mie_pkg::OP_DECREMENT_SKIP_ZERO_ACC: begin
                     r = (i_op == mie_pkg::OP_INCREMENT_SKIP_ZERO_ACC) ? i_mem + 8'h01
                                                    : i_mem - 8'h01;
                     s_d.acc = r; // [RL12]
                     skp = is_zero(r);
                  end
                  mie_pkg::OP_TRD_CUR, mie_pkg::OP_TRD_LAST: begin
                     r = i_rom[7:0]; // [RL13]
                     s_d.tbh = i_rom[ROM_W-1:8];
                     s_d.rreq = 1'b1;
                     s_d.rlast = (i_op == mie_pkg::OP_TRD_LAST);
                     wr = 1'b1;
                     cyc2 = 1'b1; // [RL13]
                  end
                  mie_pkg::OP_CLR: begin
                     r = `MIE_ZERO_BYTE;
                     wr = 1'b1;
                  end
                  mie_pkg::OP_SET: begin
                     r = ~`MIE_ZERO_BYTE;
                     wr = 1'b1;
                  end
                  mie_pkg::OP_CLRWDT: begin
                     s_d.wdt = 1'b1;
                     s_d.to = 1'b0;
                     s_d.powerdown_flag = 1'b0;
                     s_d.pre1 = 1'b0;
                     s_d.pre2 = 1'b0;
                  end
                  mie_pkg::OP_WDT1, mie_pkg::OP_WDT2: begin
                     // a lone preclear only records itself
                     if ((i_op == mie_pkg::OP_WDT1 && s_q.pre2) ||
                         (i_op == mie_pkg::OP_WDT2 && s_q.pre1)) begin
                        s_d.wdt = 1'b1; // [RL21]
                        s_d.to = 1'b0; // [RL17]
                        s_d.powerdown_flag = 1'b0; // [RL17]
                        s_d.pre1 = 1'b0;
                        s_d.pre2 = 1'b0;
                     end else if (i_op == mie_pkg::OP_WDT1) begin
                        s_d.pre1 = 1'b1; // [RL18]
                     end else begin
                        s_d.pre2 = 1'b1; // [RL18]
                     end
                  end
                  mie_pkg::OP_SWAP: begin
                     r = {i_mem[3:0], i_mem[7:4]}; // [RL14]
                     wr = 1'b1;
                  end
                  mie_pkg::OP_NIBBLE_EXCHANGE_TO_ACCUMULATOR: begin
                     s_d.acc = {i_mem[3:0], i_mem[7:4]}; // [RL14]
                  end
                  mie_pkg::OP_HALT: begin
                     s_d.wdt = 1'b1; // [RL20]
                     s_d.powerdown_flag = 1'b1; // [RL20]
                     s_d.to = 1'b0;
                     s_d.pre1 = 1'b0;
                     s_d.pre2 = 1'b0;
                  end
                  default: ;
               endcase
               s_d.we = wr;
               s_d.wd = r;
               s_d.skip = skp;
               s_d.program_counter_low = wr && (i_addr == `MIE_PCL_ADDR);
               // base length one cycle, each penalty one more
               // penalties stack: a pcl write that also skips costs three
               s_d.cnt = {2'b00, `MIE_CLKS_PER_CYC} - 5'h01; // [RL22]
               if (cyc2)
                  s_d.cnt = s_d.cnt + {2'b00, `MIE_CLKS_PER_CYC}; // [RL8]
               if (wr && (i_addr == `MIE_PCL_ADDR))
                  s_d.cnt = s_d.cnt + {2'b00, `MIE_CLKS_PER_CYC}; // [RL15]
               if (skp)
                  s_d.cnt = s_d.cnt + {2'b00, `MIE_CLKS_PER_CYC}; // [RL16]
               s_d.st = (i_op == mie_pkg::OP_HALT) ? mie_pkg::ST_HALT
                                                   : mie_pkg::ST_EXEC;
            end
         end
         mie_pkg::ST_EXEC: begin
            if (s_q.cnt == 5'h01) begin
               s_d.st = mie_pkg::ST_IDLE;
               s_d.busy = 1'b0;
               s_d.done = 1'b1;
               s_d.cnt = 5'h00;
            end else begin
               s_d.cnt = s_q.cnt - 5'h01;
            end
         end
         mie_pkg::ST_HALT: begin
            // one cycle to finish, then held in ST_HALT until wake
            if (s_q.cnt > 5'h01) begin
               s_d.cnt = s_q.cnt - 5'h01; // [RL19]
            end else if (s_q.cnt == 5'h01) begin
               s_d.cnt = 5'h00;
               s_d.done = 1'b1; // [RL19]
            end else if (s_q.wk[2] && s_q.wk[1]) begin
               s_d.st = mie_pkg::ST_IDLE;
               s_d.busy = 1'b0;
            end
         end
         default: s_d.st = mie_pkg::ST_IDLE;
      endcase
      s_d.hlt = (s_d.st == mie_pkg::ST_HALT);
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   // reset is sampled like any input: hold it low for at least one edge
   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         s_q <= '0;
         s_q.st <= mie_pkg::ST_IDLE;
      end else begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   // nothing in this core raises the timeout flag; only the clears live here
   assign o_busy = s_q.busy;
   assign o_done = s_q.done;
   assign o_skip = s_q.skip;
   assign o_mem_we = s_q.we;
   assign o_mem_wdata = s_q.wd;
   assign o_acc = s_q.acc;
   assign o_zero = s_q.z;
   assign o_carry = s_q.c;
   assign o_table_high_latch = s_q.tbh;
   assign o_timeout_flag = s_q.to;
   assign o_powerdown_flag = s_q.powerdown_flag;
   assign o_wdt_clear = s_q.wdt;
   assign o_halted = s_q.hlt;
   assign o_rom_req = s_q.rreq;
   assign o_rom_last_page = s_q.rlast;
   assign o_pc_load = s_q.program_counter_low;
endmodule

// [common/mie_defs.svh]
// How it works
// RL1: immediate and/or/xor into acc, zero flag only
// RL2: complement byte; acc variant spares memory; zero flag
// RL3: increment/decrement to memory or acc; zero flag
// RL4: plain rotates circulate eight bits, no flags
// RL5: carry rotates form nine-bit loop, carry only
// RL6: moves alter no flag
// RL7: clear or set one bit 0..7
// RL8: jump, call, returns take two cycles
// RL9: skip on zero byte or bit state
// RL10: test zero with move copies byte to acc
// RL11: inc/dec skip write memory, skip on zero
// RL12: acc inc/dec skip spare memory, skip on zero
// RL13: table read low to memory, high to latch, two cycles
// RL14: nibble swap to memory or acc, no flags
// RL15: program counter low write adds one cycle
// RL16: taken skip adds one cycle
// RL17: real watchdog clear clears timeout and powerdown
// RL18: lone preclear leaves timeout and powerdown unchanged
// RL19: power-down finishes in one cycle
// RL20: power-down halts, clears watchdog, sets powerdown flag
// RL21: paired clear clears watchdog only after both preclears
// RL22: everything else takes one cycle
`ifndef MIE_DEFS_SVH
`define MIE_DEFS_SVH
`define MIE_CLKS_PER_CYC 3'h4
`define MIE_PCL_ADDR 8'h02
`define MIE_ZERO_BYTE 8'h00
`endif

// [common/mie_pkg.sv]
package mie_pkg;
   typedef enum logic [5:0] {
      OP_NOP, OP_AND_X, OP_OR_X, OP_XOR_X, OP_CPL, OP_COMPLEMENT_TO_ACCUMULATOR,
      OP_INC, OP_INCREMENT_TO_ACCUMULATOR, OP_DEC, OP_DECREMENT_TO_ACCUMULATOR, OP_RR, OP_RRA, OP_RL, OP_RLA,
      OP_RRC, OP_RRCA, OP_RLC, OP_RLCA, OP_MOV_AM, OP_MOV_MA, OP_MOV_AX,
      OP_CLR_BIT, OP_SET_BIT, OP_JMP, OP_SZ, OP_SZA, OP_SZ_BIT, OP_SNZ_BIT,
      OP_SIZ, OP_SDZ, OP_INCREMENT_SKIP_ZERO_ACC, OP_DECREMENT_SKIP_ZERO_ACC, OP_CALL, OP_RET, OP_RET_X, OP_INTERRUPT_RETURN,
      OP_TRD_CUR, OP_TRD_LAST, OP_CLR, OP_SET, OP_CLRWDT, OP_WDT1, OP_WDT2,
      OP_SWAP, OP_NIBBLE_EXCHANGE_TO_ACCUMULATOR, OP_HALT
   } mie_op_e;
   typedef enum {ST_IDLE, ST_EXEC, ST_WAIT, ST_HALT} mie_st_e;
endpackage

// [testbench/mie_core_monitor.sv]
`timescale 1ns/1ps
module mie_core_monitor (
   input wire logic i_mclk,
   input wire logic i_rst_b,
   input wire logic i_start,
   input wire mie_pkg::mie_op_e i_op,
   input wire logic [7:0] i_mem,
   input wire logic [7:0] i_imm,
   input wire logic [2:0] i_bit,
   input wire logic o_busy,
   input wire logic o_done,
   input wire logic o_mem_we,
   input wire logic [7:0] o_mem_wdata,
   input wire logic [7:0] o_acc,
   input wire logic o_zero,
   input wire logic o_carry,
   input wire logic o_timeout_flag,
   input wire logic o_powerdown_flag
);
   // ---
   // checks tied to the accepting edge
   // ---
   logic tk;
   assign tk = i_start && !o_busy;
   default clocking @(posedge i_mclk); endclocking
   default disable iff (!i_rst_b);
   chk_xor_imm: assert property (
      tk && i_op == mie_pkg::OP_XOR_X |-> ##1 o_zero == (o_acc == 8'h00)
      && o_acc == ($past(o_acc) ^ $past(i_imm))) else $error("bad xor");
   chk_short_done: assert property (
      tk && i_op inside {mie_pkg::OP_NOP, mie_pkg::OP_MOV_AX}
      |-> ##1 !o_done [*3] ##1 o_done) else $error("bad short timing");
   chk_long_done: assert property (
      tk && i_op inside {mie_pkg::OP_JMP, mie_pkg::OP_INTERRUPT_RETURN}
      |-> ##1 !o_done [*7] ##1 o_done) else $error("bad long timing");
   chk_move_flags: assert property (
      tk && i_op inside {mie_pkg::OP_MOV_AM, mie_pkg::OP_MOV_MA}
      |-> ##1 $stable({o_zero, o_carry})) else $error("move hit flags");
   chk_rot_plain: assert property (
      tk && i_op == mie_pkg::OP_RRA |-> ##1 $stable(o_carry)
      && {o_acc[6:0], o_acc[7]} == $past(i_mem)) else $error("bad rotate");
   chk_rot_carry: assert property (
      tk && i_op == mie_pkg::OP_RLC |-> ##1 o_mem_we &&
      {o_carry, o_mem_wdata} == {$past(i_mem), $past(o_carry)})
      else $error("bad carry rotate");
   chk_bit_set: assert property (
      tk && i_op == mie_pkg::OP_SET_BIT |-> ##1 o_mem_we &&
      o_mem_wdata == ($past(i_mem) | (8'h01 << $past(i_bit))))
      else $error("bad bit set");
   chk_halt_flags: assert property (
      tk && i_op == mie_pkg::OP_HALT |-> ##1
      o_powerdown_flag && !o_timeout_flag) else $error("bad halt flags");
endmodule
bind mie_core mie_core_monitor u_mon (.i_mclk, .i_rst_b, .i_start, .i_op,
   .i_mem, .i_imm, .i_bit, .o_busy, .o_done, .o_mem_we, .o_mem_wdata,
   .o_acc, .o_zero, .o_carry, .o_timeout_flag, .o_powerdown_flag);

// [testbench/mie_mem_model.sv]
`timescale 1ns/1ps
module mie_mem_model (
   input wire logic i_mclk,
   input wire logic [7:0] i_addr,
   input wire logic i_we,
   input wire logic [7:0] i_wdata,
   output logic [7:0] o_mem,
   output logic [13:0] o_rom
);
   // ---
   // data and program memory
   // ---
   logic [7:0] ram_q [256];
   initial foreach (ram_q[k]) ram_q[k] = 8'(k * 37);
   always @(posedge i_mclk) if (i_we) ram_q[i_addr] <= i_wdata;
   // combinational read: the operand is there with the request
   assign o_mem = ram_q[i_addr];
   // rom word derived from the address, so no storage is needed
   assign o_rom = {i_addr[5:0], ~i_addr};
endmodule

// [testbench/mie_core_bench.sv]
`timescale 1ns/1ps
`include "mie_defs.svh"
module mie_core_bench;
   logic i_mclk = 1'b0;
   logic i_rst_b = 1'b0;
   logic i_start = 1'b0;
   mie_pkg::mie_op_e i_op = mie_pkg::OP_NOP;
   logic [7:0] i_addr = 8'h00;
   logic [7:0] i_imm = 8'h00;
   logic [2:0] i_bit = 3'h0;
   logic i_wake = 1'b0;
   logic [7:0] i_mem, o_mem_wdata, o_acc, e_acc;
   logic [13:0] i_rom;
   logic [5:0] o_table_high_latch;
   logic o_busy, o_done, o_skip, o_mem_we, o_zero, o_carry, o_halted;
   logic o_timeout_flag, o_powerdown_flag, o_wdt_clear, o_pc_load;
   logic o_rom_req, o_rom_last_page, e_z, e_c, e_to, e_pd, w1, w2;
   int n_fail = 0;
   int checked = 0;
   int tmo = 0;
   int dk[] = '{38, 24, 25, 26, 27, 39, 27, 28, 31, 39, 28, 30, 38, 29,
      39, 30};
   int wk[] = '{45, 41, 41, 42, 45, 42, 40, 45, 41, 42};
   always #5 i_mclk = ~i_mclk;
   mie_core uut (.i_mclk, .i_rst_b, .i_start, .i_op, .i_addr, .i_mem,
      .i_imm, .i_bit, .i_rom, .i_wake, .o_busy, .o_done, .o_skip, .o_mem_we,
      .o_mem_wdata, .o_acc, .o_zero, .o_carry, .o_table_high_latch,
      .o_timeout_flag, .o_powerdown_flag, .o_wdt_clear, .o_halted,
      .o_rom_req, .o_rom_last_page, .o_pc_load);
   mie_mem_model u_mem (.i_mclk, .i_addr, .i_we(o_mem_we),
      .i_wdata(o_mem_wdata), .o_mem(i_mem), .o_rom(i_rom));
   task automatic chk(input string nm, input logic [31:0] got, exp);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %0h seen %0h", nm, exp, got);
      end
   endtask
   task automatic results;
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // ---
   // reference model; k is the position in mie_op_e
   // ---
   task automatic run(input int k, input logic [7:0] a, input logic [2:0] b);
      logic [7:0] m, r, wd;
      logic tm, ta, sk, pc;
      int n, ec;
      int cy = 0;
      int nw = 0;
      int nc = 0;
      int np = 0;
      int nr = 0;
      i_op <= mie_pkg::mie_op_e'(k);
      i_addr <= a;
      i_imm <= 8'($urandom);
      i_bit <= b;
      i_start <= 1'b1;
      @(posedge i_mclk);
      i_start <= 1'b0;
      m = i_mem;
      case (k)
         1: r = e_acc & i_imm;
         2: r = e_acc | i_imm;
         3: r = e_acc ^ i_imm;
         4, 5: r = ~m;
         6, 7, 28, 30: r = m + 8'h01;
         8, 9, 29, 31: r = m - 8'h01;
         10, 11: r = {m[0], m[7:1]};
         12, 13: r = {m[6:0], m[7]};
         14, 15: {r, e_c} = {e_c, m};
         16, 17: {e_c, r} = {m, e_c};
         19: r = e_acc;
         20, 34: r = i_imm;
         21: r = m & ~(8'h01 << b);
         22: r = m | (8'h01 << b);
         36, 37: r = i_rom[7:0];
         38: r = 8'h00;
         39: r = 8'hFF;
         43, 44: r = {m[3:0], m[7:4]};
         default: r = m;
      endcase
      tm = (k inside {[4:17]} && !k[0]) || k inside {19, 21, 22, 28, 29,
         [36:39], 43};
      ta = (k inside {[4:17]} && k[0]) || k inside {[1:3], 18, 20, 25, 30,
         31, 34, 44};
      sk = k inside {24, 25} ? m == 8'h00 : k == 26 ? !m[b] :
         k == 27 ? m[b] : k inside {[28:31]} && r == 8'h00;
      pc = tm && a == `MIE_PCL_ADDR;
      n = 1 + int'(k inside {23, [32:37]}) + int'(pc) + int'(sk);
      if (ta) e_acc = r;
      if (k inside {[1:9]}) e_z = r == 8'h00;
      w1 |= k == 41;
      w2 |= k == 42;
      ec = int'((w1 && w2) || k inside {40, 45});
      if (ec) begin
         e_pd = k == 45;
         e_to = 1'b0;
         w1 = 1'b0;
         w2 = 1'b0;
      end
      repeat (40) begin
         @(posedge i_mclk);
         cy++;
         nw += int'(o_mem_we === 1'b1);
         nc += int'(o_wdt_clear === 1'b1);
         np += int'(o_pc_load === 1'b1);
         nr += int'(o_rom_req === 1'b1);
         if (o_mem_we === 1'b1) wd = o_mem_wdata;
         if (o_done === 1'b1) break;
      end
      chk("cycles", cy, 4 * n);
      chk("writes", nw, int'(tm));
      if (tm) chk("wdata", wd, r);
      chk("pcl", np, int'(pc));
      chk("acc", o_acc, e_acc);
      chk("flags", {o_zero, o_carry}, {e_z, e_c});
      chk("skip", o_skip, sk);
      chk("status", {o_timeout_flag, o_powerdown_flag},
         {e_to, e_pd});
      chk("wdt", nc, ec);
      chk("romreq", nr, int'(k inside {36, 37}));
      if (k inside {36, 37}) begin
         chk("latch", o_table_high_latch, i_rom[13:8]);
         chk("page", o_rom_last_page, k == 37);
      end
      if (k == 45) begin
         chk("halted", o_halted, 1'b1);
         i_wake <= 1'b1;
         repeat (20) begin
            @(posedge i_mclk);
            if (o_busy === 1'b0) break;
         end
         i_wake <= 1'b0;
      end
   endtask
   always @(posedge i_mclk) begin
      tmo++;
      if (tmo == 30000) begin
         n_fail++;
         results();
      end
   end
   // ---
   // sequence: every op but the watchdog and halt ones, corner cases, watchdog, then random
   // ---
   initial begin
      int rk;
      {e_acc, e_z, e_c, e_to, e_pd, w1, w2} = '0;
      void'($urandom(73));
      repeat (5) @(posedge i_mclk);
      i_rst_b <= 1'b1;
      chk("reset", {o_busy, o_acc, o_zero, o_powerdown_flag}, 32'h0);
      for (int k = 0; k < 42; k++) run(k < 40 ? k : k + 3, 8'(k), 3'(k));
      foreach (dk[i]) run(dk[i], i < 9 ? 8'h05 : 8'h02, 3'(i));
      foreach (wk[i]) run(wk[i], 8'h10, 3'h0);
      repeat (150) begin
         rk = $urandom_range(0, 41);
         run(rk < 40 ? rk : rk + 3, 8'($urandom_range(0, 7)), 3'($urandom));
      end
      results();
   end
endmodule
